/* File: operand_address_and_repeat_loop.sv */
`timescale 1ns/1ps
`include "addr_loop_regs.svh"

module operand_address_and_repeat_loop #(
  parameter int AUX_N = `AUX_COUNT,
  parameter int PAGE_W = `DATA_PAGE_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire addr_loop_pkg::operand_req_t req,
  input wire logic [PAGE_W-1:0] data_page_pointer,
  input wire logic aux_select_load,
  input wire logic [2:0] aux_select_data,
  input wire logic aux_wr,
  input wire logic [2:0] aux_wr_index,
  input wire logic [15:0] aux_wr_data,
  input wire logic circ_wr,
  input wire logic [2:0] circ_wr_which,
  input wire logic [15:0] circ_wr_data,
  input wire logic repeat_single_op,
  input wire logic repeat_single_clear_op,
  input wire logic [15:0] repeat_count,
  input wire logic instr_issue,
  input wire logic irq_pending,
  input wire logic nmi_pending,
  input wire logic hold_req,
  input wire logic block_count_wr,
  input wire logic [15:0] block_count_data,
  input wire logic block_loop_op,
  input wire logic [15:0] block_op_next_pc,
  input wire logic [15:0] block_op_end_addr,
  input wire logic mode_status_wr,
  input wire logic mode_status_flag_data,
  input wire logic pc_update,
  input wire logic [15:0] pc,
  output addr_loop_pkg::operand_res_t res,
  output logic [2:0] aux_select_pointer,
  output logic [15:0] single_repeat_counter,
  output logic repeat_active,
  output logic refetch_hold,
  output logic irq_take,
  output logic nmi_take,
  output logic hold_ack,
  output logic clear_acc_prod,
  output logic pc_redirect,
  output logic [15:0] pc_redirect_addr,
  output logic block_loop_active_flag,
  output logic [15:0] block_loop_count
);

  // refuse parameter values that the fixed-width fields cannot serve
  if (AUX_N != (1 << `AUX_SEL_W)) begin : g_bad_aux
    $error("aux pointer count must match select width");
  end
  if (PAGE_W + `DIRECT_OFFSET_W != `DATA_ADDR_W) begin : g_bad_page
    $error("page and offset must fill the address");
  end
  if (`PERIPH_EXTRA_CYCLES > 1) begin : g_bad_stall
    $error("stall flag covers a single extra cycle only");
  end

  // reset release through two flops
  // every flop behind the two leaves reset on the same edge, whatever the phase of rst_n
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_core_n = rst_s2_reg;

  // select pointer
  logic [2:0] sel_reg;
  wire [15:0] aux_val [AUX_N];
  wire [15:0] cur_aux = aux_val[sel_reg];

  // circular registers: two starts, two ends, one control
  logic [15:0] circ_start_reg [2];
  logic [15:0] circ_end_reg [2];
  logic [7:0] circ_ctrl_reg;

  wire [2:0] buf0_aux = circ_ctrl_reg[`CIRC_CTRL_BUF0_AUX_LSB +: 3];
  wire [2:0] buf1_aux = circ_ctrl_reg[`CIRC_CTRL_BUF1_AUX_LSB +: 3];
  wire buf0_en = circ_ctrl_reg[`CIRC_CTRL_BUF0_EN];
  wire buf1_en = circ_ctrl_reg[`CIRC_CTRL_BUF1_EN];

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      circ_start_reg[0] <= 16'h0000;
      circ_start_reg[1] <= 16'h0000;
      circ_end_reg[0] <= 16'h0000;
      circ_end_reg[1] <= 16'h0000;
      circ_ctrl_reg <= `CIRC_CTRL_RESET;
    end else if (circ_wr) begin
      // software must fill these before the first circular access
      if (circ_wr_which == 3'h0) circ_start_reg[0] <= circ_wr_data;
      else if (circ_wr_which == 3'h1) circ_end_reg[0] <= circ_wr_data;
      else if (circ_wr_which == 3'h2) circ_start_reg[1] <= circ_wr_data;
      else if (circ_wr_which == 3'h3) circ_end_reg[1] <= circ_wr_data;
      else if (circ_wr_which == 3'h4) circ_ctrl_reg <= circ_wr_data[7:0];
    end
  end

  wire ind_access = req.valid && (req.mode == addr_loop_pkg::mode_indirect ||
                                  req.mode == addr_loop_pkg::mode_circular);
  // a circular request on a pointer that control does not name acts as plain indirect
  wire circ_mode = req.mode == addr_loop_pkg::mode_circular;

  genvar g;
  generate
    for (g = 0; g < AUX_N; g++) begin : g_aux
      wire on0 = circ_mode && buf0_en && (buf0_aux == 3'(g));
      wire on1 = circ_mode && buf1_en && (buf1_aux == 3'(g));
      aux_pointer #(.WIDTH(16)) u_aux (
        .mclk(mclk),
        .rst_n(rst_core_n),
        .sel(sel_reg == 3'(g)),
        .step(ind_access),
        .update(req.update),
        .index(aux_val[0]),
        .circ_en(on0 || on1),
        .circ_start(on1 ? circ_start_reg[1] : circ_start_reg[0]),
        .circ_end(on1 ? circ_end_reg[1] : circ_end_reg[0]),
        .wr_en(aux_wr && aux_wr_index == 3'(g)),
        .wr_data(aux_wr_data),
        .value(aux_val[g])
      );
    end
  endgenerate

  // select changes after the access, same cycle as the pointer update
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) sel_reg <= 3'h0;
    else if (aux_select_load) sel_reg <= aux_select_data;
    else if (ind_access && req.next_sel_load) sel_reg <= req.next_sel;
  end

  // operand address and data formation
  wire [15:0] direct_addr = {data_page_pointer, req.offset};
  wire [15:0] mmap_addr = {9'h000, req.offset};
  wire is_addr = req.valid && (req.mode == addr_loop_pkg::mode_direct ||
                               req.mode == addr_loop_pkg::mode_mmapped || ind_access);
  wire is_data = req.valid && (req.mode == addr_loop_pkg::mode_short_imm ||
                               req.mode == addr_loop_pkg::mode_long_imm ||
                               req.mode == addr_loop_pkg::mode_register);
  wire [15:0] addr_sel = (req.mode == addr_loop_pkg::mode_direct) ? direct_addr :
                         (req.mode == addr_loop_pkg::mode_mmapped) ? mmap_addr : cur_aux;
  wire [15:0] data_sel = (req.mode == addr_loop_pkg::mode_short_imm) ? req.short_imm :
                         (req.mode == addr_loop_pkg::mode_long_imm) ? req.long_imm :
                         req.reg_value;
  // the stall is only flagged; the data-memory side inserts the wait cycle
  wire periph_hit = is_addr && addr_sel >= `PERIPH_LO &&
                    addr_sel <= `PERIPH_HI;

  addr_loop_pkg::operand_res_t res_reg;
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) res_reg <= '0;
    else begin
      res_reg.addr_valid <= is_addr;
      res_reg.addr <= addr_sel;
      res_reg.data_valid <= is_data;
      res_reg.data <= data_sel;
      res_reg.periph_stall <= periph_hit && (`PERIPH_EXTRA_CYCLES != 0);
    end
  end

  // single repeat
  // the counter holds the repeats still owed after the issue in flight
  logic [15:0] rpt_reg;
  logic rpt_armed_reg;
  logic rpt_run_reg;
  logic clear_reg;
  wire rpt_load = repeat_single_op || repeat_single_clear_op;
  wire rpt_last = rpt_run_reg && instr_issue && (rpt_reg == 16'h0000);

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      rpt_reg <= `SINGLE_REPEAT_RESET;
      rpt_armed_reg <= 1'b0;
      rpt_run_reg <= 1'b0;
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= repeat_single_clear_op;
      if (rpt_load) begin
        rpt_reg <= repeat_count;
        rpt_armed_reg <= 1'b1;
      end else if (rpt_armed_reg && instr_issue) begin
        // first execution of the repeated instruction
        rpt_armed_reg <= 1'b0;
        rpt_run_reg <= (rpt_reg != 16'h0000);
        if (rpt_reg != 16'h0000) rpt_reg <= rpt_reg - 16'h0001;
      end else if (rpt_run_reg && instr_issue) begin
        if (rpt_last) rpt_run_reg <= 1'b0;
        else rpt_reg <= rpt_reg - 16'h0001;
      end
    end
  end

  wire rpt_busy = rpt_load || rpt_armed_reg || rpt_run_reg;

  // gating starts at the load strobe so no interrupt slips in before the first issue
  logic irq_reg;
  logic nmi_reg;
  logic hold_reg;
  logic refetch_reg;
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      irq_reg <= 1'b0;
      nmi_reg <= 1'b0;
      hold_reg <= 1'b0;
      refetch_reg <= 1'b0;
    end else begin
      irq_reg <= irq_pending && !rpt_busy;
      nmi_reg <= nmi_pending && !rpt_busy;
      hold_reg <= hold_req;
      // holding fetch lets repeated multicycle ops issue every cycle
      refetch_reg <= rpt_busy && !rpt_last;
    end
  end

  // block loop
  // the end bound stays inside the loop unit; the flag, the count and the redirect with the start address leave the block
  logic redir;
  logic [15:0] redir_pc;
  logic blk_active;
  logic [15:0] blk_count;
  block_loop #(.AW(16)) u_block (
    .mclk(mclk),
    .rst_n(rst_core_n),
    .count_wr(block_count_wr),
    .count_data(block_count_data),
    .start_op(block_loop_op),
    .op_next_pc(block_op_next_pc),
    .op_end_addr(block_op_end_addr),
    .flag_wr(mode_status_wr),
    .flag_data(mode_status_flag_data),
    .pc_update(pc_update),
    .pc(pc),
    .redirect(redir),
    .redirect_pc(redir_pc),
    .active(blk_active),
    .count(blk_count),
    .start_addr(),
    .end_addr()
  );

  // the redirect is registered to come straight off a flop, at one cycle of latency
  logic redir_reg;
  logic [15:0] redir_pc_reg;
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      redir_reg <= 1'b0;
      redir_pc_reg <= 16'h0000;
    end else begin
      redir_reg <= redir;
      redir_pc_reg <= redir_pc;
    end
  end

  assign res = res_reg;
  assign aux_select_pointer = sel_reg;
  assign single_repeat_counter = rpt_reg;
  assign repeat_active = rpt_run_reg;
  assign refetch_hold = refetch_reg;
  assign irq_take = irq_reg;
  assign nmi_take = nmi_reg;
  assign hold_ack = hold_reg;
  assign clear_acc_prod = clear_reg;
  assign pc_redirect = redir_reg;
  assign pc_redirect_addr = redir_pc_reg;
  assign block_loop_active_flag = blk_active;
  assign block_loop_count = blk_count;

endmodule

/* File: addr_loop_regs.svh */
`ifndef ADDR_LOOP_REGS_SVH
`define ADDR_LOOP_REGS_SVH

// direct address: page pointer above the in-page offset
`define DIRECT_OFFSET_W 7
`define DATA_PAGE_W 9
`define DATA_ADDR_W 16
`define AUX_COUNT 8
`define AUX_SEL_W 3
// peripheral register window on data page zero
`define PERIPH_LO 16'h0020
`define PERIPH_HI 16'h004f
// reset values
`define SINGLE_REPEAT_RESET 16'h0000
`define BLOCK_LOOP_COUNT_RESET 16'h0000
`define AUX_RESET 16'h0000
`define CIRC_CTRL_RESET 8'h00
// circular control field positions
`define CIRC_CTRL_BUF0_AUX_LSB 0
`define CIRC_CTRL_BUF0_EN 3
`define CIRC_CTRL_BUF1_AUX_LSB 4
`define CIRC_CTRL_BUF1_EN 7
// extra wait cycles for a peripheral access
`define PERIPH_EXTRA_CYCLES 1

`endif

/* File: addr_loop_pkg.sv */
package addr_loop_pkg;

  typedef enum logic [2:0] {
    upd_none,
    upd_inc,
    upd_dec,
    upd_add_idx,
    upd_sub_idx,
    upd_rev_inc,
    upd_rev_dec
  } aux_update_t;

  typedef enum logic [2:0] {
    mode_direct,
    mode_indirect,
    mode_short_imm,
    mode_long_imm,
    mode_register,
    mode_mmapped,
    mode_circular
  } addr_mode_t;

  // operand request from decode
  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    logic [6:0] offset;
    aux_update_t update;
    logic next_sel_load;
    logic [2:0] next_sel;
    logic [15:0] short_imm;
    logic [15:0] long_imm;
    logic [15:0] reg_value;
  } operand_req_t;

  // operand result toward data memory
  typedef struct packed {
    logic addr_valid;
    logic [15:0] addr;
    logic data_valid;
    logic [15:0] data;
    logic periph_stall;
  } operand_res_t;

endpackage

/* File: aux_pointer.sv */
`timescale 1ns/1ps
`include "addr_loop_regs.svh"

// one auxiliary pointer register with its post-access update
module aux_pointer #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel,
  input wire logic step,
  input wire addr_loop_pkg::aux_update_t update,
  input wire logic [WIDTH-1:0] index,
  input wire logic circ_en,
  input wire logic [WIDTH-1:0] circ_start,
  input wire logic [WIDTH-1:0] circ_end,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] value
);

  if (WIDTH < 2) begin : g_bad_width
    $error("aux_pointer width too small");
  end

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;
  logic [WIDTH-1:0] rev_val;
  logic [WIDTH-1:0] rev_idx;
  logic [WIDTH-1:0] stepped;

  // bit-reversed carry: reverse, add, reverse back
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      rev_val[i] = value_reg[WIDTH-1-i];
      rev_idx[i] = index[WIDTH-1-i];
    end
  end

  logic [WIDTH-1:0] rev_sum;
  logic [WIDTH-1:0] rev_dif;
  logic [WIDTH-1:0] rev_sum_back;
  logic [WIDTH-1:0] rev_dif_back;
  assign rev_sum = rev_val + rev_idx;
  assign rev_dif = rev_val - rev_idx;
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      rev_sum_back[i] = rev_sum[WIDTH-1-i];
      rev_dif_back[i] = rev_dif[WIDTH-1-i];
    end
  end

  always_comb begin
    case (update)
      addr_loop_pkg::upd_inc: stepped = value_reg + WIDTH'(1);
      addr_loop_pkg::upd_dec: stepped = value_reg - WIDTH'(1);
      addr_loop_pkg::upd_add_idx: stepped = value_reg + index;
      addr_loop_pkg::upd_sub_idx: stepped = value_reg - index;
      addr_loop_pkg::upd_rev_inc: stepped = rev_sum_back;
      addr_loop_pkg::upd_rev_dec: stepped = rev_dif_back;
      default: stepped = value_reg;
    endcase
  end

  // wrap to buffer start once the last location has been used
  wire circ_wrap = circ_en && (value_reg == circ_end) && (update != addr_loop_pkg::upd_none);

  always_comb begin
    value_next = value_reg;
    if (wr_en) value_next = wr_data;
    else if (sel && step) value_next = circ_wrap ? circ_start : stepped;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) value_reg <= WIDTH'(`AUX_RESET);
    else value_reg <= value_next;
  end

  assign value = value_reg;

endmodule

/* File: block_loop.sv */
`timescale 1ns/1ps
`include "addr_loop_regs.svh"

// zero-overhead block loop: start/end/count and the active flag
module block_loop #(
  parameter int AW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic count_wr,
  input wire logic [15:0] count_data,
  input wire logic start_op,
  input wire logic [AW-1:0] op_next_pc,
  input wire logic [AW-1:0] op_end_addr,
  input wire logic flag_wr,
  input wire logic flag_data,
  input wire logic pc_update,
  input wire logic [AW-1:0] pc,
  output logic redirect,
  output logic [AW-1:0] redirect_pc,
  output logic active,
  output logic [15:0] count,
  output logic [AW-1:0] start_addr,
  output logic [AW-1:0] end_addr
);

  if (AW < 1) begin : g_bad_aw
    $error("block_loop address width invalid");
  end

  logic [15:0] count_reg;
  logic [AW-1:0] start_reg;
  logic [AW-1:0] end_reg;
  logic active_reg;

  wire at_end = active_reg && pc_update && (pc == end_reg);
  wire loop_back = at_end && (count_reg != 16'h0000);
  wire loop_exit = at_end && (count_reg == 16'h0000);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `BLOCK_LOOP_COUNT_RESET;
      start_reg <= '0;
      end_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      if (count_wr) count_reg <= count_data;
      else if (loop_back) count_reg <= count_reg - 16'h0001;
      if (start_op) begin
        start_reg <= op_next_pc;
        end_reg <= op_end_addr;
      end
      // a software clear lets the pass finish and stops the next loop-back
      if (start_op) active_reg <= 1'b1;
      else if (flag_wr) active_reg <= flag_data;
      else if (loop_exit) active_reg <= 1'b0;
    end
  end

  // branches away do not touch the flag, so re-entry resumes looping
  assign redirect = loop_back;
  assign redirect_pc = start_reg;
  assign active = active_reg;
  assign count = count_reg;
  assign start_addr = start_reg;
  assign end_addr = end_reg;

endmodule

/* File: operand_address_and_repeat_loop_checker.sv */
`timescale 1ns/1ps
module operand_address_and_repeat_loop_checker #(
  parameter int AUX_N = 8,
  parameter int PAGE_W = 9
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire addr_loop_pkg::operand_req_t req,
  input wire logic [PAGE_W-1:0] data_page_pointer,
  input wire logic repeat_single_op,
  input wire logic repeat_single_clear_op,
  input wire logic instr_issue,
  input wire logic hold_req,
  input wire logic block_loop_op,
  input wire logic [15:0] block_op_next_pc,
  input wire logic [15:0] block_op_end_addr,
  input wire logic mode_status_wr,
  input wire logic pc_update,
  input wire logic [15:0] pc,
  input wire addr_loop_pkg::operand_res_t res,
  input wire logic [15:0] single_repeat_counter,
  input wire logic repeat_active,
  input wire logic irq_take,
  input wire logic nmi_take,
  input wire logic hold_ack,
  input wire logic clear_acc_prod,
  input wire logic pc_redirect,
  input wire logic [15:0] pc_redirect_addr,
  input wire logic block_loop_active_flag,
  input wire logic [15:0] block_loop_count
);
  logic [15:0] start_reg;
  logic [15:0] end_reg;
  // shadow of the loop bounds, since the top does not expose them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 16'h0000;
      end_reg <= 16'h0000;
    end else if (block_loop_op) begin
      start_reg <= block_op_next_pc;
      end_reg <= block_op_end_addr;
    end
  end
  wire loop_hit = pc_update && pc == end_reg && block_loop_active_flag && !block_loop_op && !mode_status_wr;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_direct_addr: assert property (
    req.valid && req.mode == addr_loop_pkg::mode_direct |=> res.addr_valid
    && res.addr == {$past(data_page_pointer), $past(req.offset)}) else $error("direct address wrong");
  chk_mmap_page: assert property (
    req.valid && req.mode == addr_loop_pkg::mode_mmapped |=> res.addr_valid
    && res.addr == {9'h000, $past(req.offset)}) else $error("page zero address wrong");
  chk_short_imm: assert property (
    req.valid && req.mode == addr_loop_pkg::mode_short_imm |=> res.data_valid
    && res.data == $past(req.short_imm)) else $error("short immediate wrong");
  chk_periph_stall: assert property (
    res.addr_valid |-> res.periph_stall == (res.addr >= 16'h0020 && res.addr <= 16'h004f))
    else $error("peripheral stall wrong");
  chk_repeat_step: assert property (
    instr_issue && repeat_active && single_repeat_counter != 16'h0000 && !repeat_single_op
    |=> single_repeat_counter == $past(single_repeat_counter) - 16'h0001) else $error("repeat count step wrong");
  chk_clear_pulse: assert property (
    repeat_single_clear_op |=> clear_acc_prod ##1 !clear_acc_prod) else $error("clear pulse wrong");
  chk_irq_masked: assert property (
    repeat_active |-> !irq_take && !nmi_take) else $error("interrupt taken in repeat");
  chk_flag_set: assert property (
    block_loop_op |=> block_loop_active_flag) else $error("loop flag not set");
  chk_hold_ack: assert property (
    hold_req |=> hold_ack) else $error("hold not honoured");
  chk_loop_back: assert property (
    loop_hit && block_loop_count != 16'h0000 |=> pc_redirect && pc_redirect_addr == start_reg
    && block_loop_count == $past(block_loop_count) - 16'h0001) else $error("loop back wrong");
  chk_loop_exit: assert property (
    loop_hit && block_loop_count == 16'h0000 |=> !pc_redirect && !block_loop_active_flag)
    else $error("loop exit wrong");
endmodule

/* File: operand_address_and_repeat_loop_tb.sv */
`timescale 1ns/1ps
module operand_address_and_repeat_loop_tb;
  logic mclk, rst_n, aux_select_load, aux_wr, circ_wr, repeat_single_op, repeat_single_clear_op;
  logic instr_issue, irq_pending, nmi_pending, hold_req, block_count_wr, block_loop_op;
  logic mode_status_wr, mode_status_flag_data, pc_update;
  logic [2:0] aux_select_data, aux_wr_index, circ_wr_which, aux_select_pointer;
  logic [8:0] data_page_pointer;
  logic [15:0] aux_wr_data, circ_wr_data, repeat_count, block_count_data, block_op_next_pc, block_op_end_addr, pc;
  logic [15:0] single_repeat_counter, pc_redirect_addr, block_loop_count;
  logic repeat_active, refetch_hold, irq_take, nmi_take, hold_ack, clear_acc_prod, pc_redirect, block_loop_active_flag;
  addr_loop_pkg::operand_req_t req;
  addr_loop_pkg::operand_res_t res;
  int error_cnt = 0;
  int comparisons = 0;
  typedef struct packed {
    addr_loop_pkg::addr_mode_t mode;
    logic [6:0] off;
    logic [8:0] page;
    logic [15:0] val;
    logic is_addr;
    logic stall;
  } row_t;
  row_t rows [9] = '{
    '{addr_loop_pkg::mode_direct, 7'h05, 9'h001, 16'h0085, 1'b1, 1'b0},
    '{addr_loop_pkg::mode_direct, 7'h7f, 9'h1ff, 16'hffff, 1'b1, 1'b0},
    '{addr_loop_pkg::mode_direct, 7'h20, 9'h000, 16'h0020, 1'b1, 1'b1},
    '{addr_loop_pkg::mode_direct, 7'h4f, 9'h000, 16'h004f, 1'b1, 1'b1},
    '{addr_loop_pkg::mode_direct, 7'h50, 9'h000, 16'h0050, 1'b1, 1'b0},
    '{addr_loop_pkg::mode_mmapped, 7'h25, 9'h1ff, 16'h0025, 1'b1, 1'b1},
    '{addr_loop_pkg::mode_short_imm, 7'h00, 9'h000, 16'h00ab, 1'b0, 1'b0},
    '{addr_loop_pkg::mode_long_imm, 7'h00, 9'h000, 16'hbeef, 1'b0, 1'b0},
    '{addr_loop_pkg::mode_register, 7'h00, 9'h000, 16'h1234, 1'b0, 1'b0}};
  addr_loop_pkg::aux_update_t ups [7] = '{addr_loop_pkg::upd_inc, addr_loop_pkg::upd_dec,
    addr_loop_pkg::upd_add_idx, addr_loop_pkg::upd_sub_idx, addr_loop_pkg::upd_rev_inc,
    addr_loop_pkg::upd_rev_dec, addr_loop_pkg::upd_none};
  logic [15:0] ind_exp [7] = '{16'h0006, 16'h0007, 16'h0006, 16'h0008, 16'h0006, 16'h0005, 16'h0006};
  logic [15:0] circ_exp [7] = '{16'h0200, 16'h0300, 16'h0201, 16'h0301, 16'h0202, 16'h0300, 16'h0200};

  operand_address_and_repeat_loop DUT (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic op(input addr_loop_pkg::addr_mode_t m, input logic [6:0] off,
                    input addr_loop_pkg::aux_update_t u, input logic [3:0] ns, input logic [15:0] v);
    req = '{1'b1, m, off, u, ns[3], ns[2:0],
            (m == addr_loop_pkg::mode_short_imm) ? v : ~v,
            (m == addr_loop_pkg::mode_long_imm) ? v : ~v,
            (m == addr_loop_pkg::mode_register) ? v : ~v};
    @(negedge mclk);
  endtask

  // each strobe is lowered a full cycle before the next one may rise
  task automatic wr(input logic circ, input logic [2:0] idx, input logic [15:0] d);
    aux_wr = !circ;
    circ_wr = circ;
    aux_wr_index = idx;
    circ_wr_which = idx;
    aux_wr_data = d;
    circ_wr_data = d;
    @(negedge mclk);
    aux_wr = 1'b0;
    circ_wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic pcstep(input logic [15:0] p, input logic exp);
    pc_update = 1'b1;
    pc = p;
    @(negedge mclk);
    check(pc_redirect, exp, "redirect");
    if (exp) check(pc_redirect_addr, 16'h0010, "loop start");
  endtask

  task automatic strobe_op(input logic clr, input logic [15:0] n);
    repeat_count = n;
    repeat_single_op = !clr;
    repeat_single_clear_op = clr;
    @(negedge mclk);
    repeat_single_op = 1'b0;
    repeat_single_clear_op = 1'b0;
    check(single_repeat_counter, n, "repeat load");
    check(refetch_hold, 1'b1, "repeat busy");
  endtask

  initial begin
    {rst_n, aux_select_load, aux_wr, circ_wr, repeat_single_op, repeat_single_clear_op, instr_issue} = '0;
    {irq_pending, nmi_pending, hold_req, block_count_wr, block_loop_op, mode_status_wr} = '0;
    {mode_status_flag_data, pc_update, aux_select_data, aux_wr_index, circ_wr_which, data_page_pointer} = '0;
    {aux_wr_data, circ_wr_data, repeat_count, block_count_data, block_op_next_pc, block_op_end_addr, pc} = '0;
    req = '0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    check(single_repeat_counter, 16'h0000, "counter at reset");
    check(block_loop_active_flag, 1'b0, "flag at reset");
    $display("reset test done");
    foreach (rows[i]) begin
      data_page_pointer = rows[i].page;
      op(rows[i].mode, rows[i].off, addr_loop_pkg::upd_none, 4'h0, rows[i].val);
      check(rows[i].is_addr ? res.addr_valid : res.data_valid, 1'b1, "valid");
      check(rows[i].is_addr ? res.addr : res.data, rows[i].val, "operand");
      if (rows[i].is_addr) check(res.periph_stall, rows[i].stall, "stall");
    end
    req = '0;
    $display("operand table done");
    wr(1'b0, 3'h0, 16'h0002);
    wr(1'b0, 3'h3, 16'h0006);
    aux_select_load = 1'b1;
    aux_select_data = 3'h3;
    @(negedge mclk);
    aux_select_load = 1'b0;
    foreach (ups[i]) begin
      op(addr_loop_pkg::mode_indirect, 7'h00, ups[i], (i == 6) ? 4'h9 : 4'h0, 16'h0000);
      check(res.addr, ind_exp[i], "indirect address");
    end
    req = '0;
    check(aux_select_pointer, 3'h1, "select after access");
    wr(1'b0, 3'h1, 16'h0200);
    wr(1'b0, 3'h2, 16'h0300);
    wr(1'b1, 3'h0, 16'h0200);
    wr(1'b1, 3'h1, 16'h0202);
    wr(1'b1, 3'h2, 16'h0300);
    wr(1'b1, 3'h3, 16'h0301);
    wr(1'b1, 3'h4, 16'h00a9);
    foreach (circ_exp[i]) begin
      op(addr_loop_pkg::mode_circular, 7'h00, addr_loop_pkg::upd_inc, i[0] ? 4'h9 : 4'ha, 16'h0000);
      check(res.addr, circ_exp[i], "circular address");
    end
    req = '0;
    $display("indirect and circular done");
    {hold_req, irq_pending, nmi_pending} = 3'b111;
    strobe_op(1'b0, 16'h0003);
    check(hold_ack, 1'b1, "hold in repeat");
    instr_issue = 1'b1;
    repeat (3) @(negedge mclk);
    check(single_repeat_counter, 16'h0000, "one per cycle");
    check({repeat_active, irq_take, nmi_take}, 3'b100, "masked");
    @(negedge mclk);
    instr_issue = 1'b0;
    check(repeat_active, 1'b0, "repeat end");
    repeat (2) @(negedge mclk);
    check({irq_take, nmi_take}, 2'b11, "unmasked");
    strobe_op(1'b1, 16'h0000);
    check({clear_acc_prod, irq_take}, 2'b10, "clear op");
    instr_issue = 1'b1;
    @(negedge mclk);
    instr_issue = 1'b0;
    check(repeat_active, 1'b0, "single run");
    strobe_op(1'b0, 16'hffff);
    instr_issue = 1'b1;
    repeat (65535) @(negedge mclk);
    check(repeat_active, 1'b1, "last run pending");
    @(negedge mclk);
    instr_issue = 1'b0;
    check(repeat_active, 1'b0, "full count done");
    {hold_req, irq_pending, nmi_pending} = 3'b000;
    $display("repeat test done");
    for (int k = 0; k < 2; k++) begin
      block_count_wr = 1'b1;
      block_count_data = k ? 16'h0005 : 16'h0002;
      @(negedge mclk);
      block_count_wr = 1'b0;
      block_loop_op = 1'b1;
      block_op_next_pc = 16'h0010;
      block_op_end_addr = 16'h0013;
      @(negedge mclk);
      block_loop_op = 1'b0;
      check(block_loop_active_flag, 1'b1, "flag set");
      if (k == 0) begin
        pcstep(16'h0011, 1'b0);
        pcstep(16'h0013, 1'b1);
        pcstep(16'h0100, 1'b0);
        check(block_loop_active_flag, 1'b1, "flag kept");
        pcstep(16'h0013, 1'b1);
        pcstep(16'h0013, 1'b0);
        check(block_loop_active_flag, 1'b0, "flag cleared");
      end else begin
        mode_status_wr = 1'b1;
        @(negedge mclk);
        mode_status_wr = 1'b0;
        pcstep(16'h0013, 1'b0);
        check(block_loop_count, 16'h0005, "early exit");
      end
      pc_update = 1'b0;
      @(negedge mclk);
    end
    $display("block loop done");
    strobe_op(1'b0, 16'h0007);
    rst_n = 1'b0;
    @(negedge mclk);
    check(single_repeat_counter, 16'h0000, "counter cleared mid-run");
    check(refetch_hold, 1'b0, "fetch released by reset");
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    check(aux_select_pointer, 3'h0, "select after reset");
    $display("mid-run reset test done");
    give_verdict();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule

bind operand_address_and_repeat_loop operand_address_and_repeat_loop_checker #(.AUX_N(AUX_N), .PAGE_W(PAGE_W)) u_chk (.*);
